// file: flash_host_regs.svh
// register offsets, field positions and timing counts of the flash host controller
`ifndef FLASH_HOST_REGS_SVH
`define FLASH_HOST_REGS_SVH

// ***************************************************
// register map, one aligned word each
// ***************************************************
`define FL_REG_CTRL 8'h00
`define FL_REG_ADDR 8'h04
`define FL_REG_WDATA 8'h08
`define FL_REG_STATUS 8'h0c
`define FL_REG_RDATA 8'h10

// ctrl fields
`define FL_CTRL_START 0
`define FL_CTRL_CMD_LO 4
`define FL_CTRL_CMD_HI 7

// status fields
`define FL_ST_BUSY 0
`define FL_ST_DONE 1
`define FL_ST_FAIL 2
`define FL_ST_LOCKED 3
`define FL_ST_USER_OPEN 4
`define FL_ST_READY_LINE 5
`define FL_ST_REFUSED 6
`define FL_ST_POR_DONE 7
`define FL_ST_SUSPENDED 8
`define FL_ST_OP_ACTIVE 9

// reset values
`define FL_ADDR_RST 19'h00000
`define FL_WDATA_RST 16'h0000

// ***************************************************
// flash command words and addresses
// ***************************************************
`define FL_A_UNLOCK1 19'h00555
`define FL_A_UNLOCK2 19'h00aaa
`define FL_A_QUERY 19'h00055
`define FL_A_USER_BLK 19'h00080
`define FL_A_LOCK_OFS 19'h00002
`define FL_D_UNLOCK1 16'h00aa
`define FL_D_UNLOCK2 16'h0055
`define FL_D_PROGRAM 16'h00a0
`define FL_D_ERASE_SETUP 16'h0080
`define FL_D_CHIP_ERASE 16'h0010
`define FL_D_SECTOR_ERASE 16'h0030
`define FL_D_LOCKDOWN 16'h0060
`define FL_D_SUSPEND 16'h00b0
`define FL_D_RESUME 16'h0030
`define FL_D_IDENT_ENTER 16'h0090
`define FL_D_IDENT_LEAVE 16'h00f0
`define FL_D_QUERY 16'h0098
`define FL_D_SEC_STORE 16'h00c0
`define FL_D_LOCK_DATA_BIT 1
`define FL_D_FAIL_BIT 5
`define FL_D_LOCK_FLAG_BIT 0

// ***************************************************
// timing
// ***************************************************
`define FL_CLK_MHZ 100
`define FL_NS_TO_CYC(ns) (((ns) * `FL_CLK_MHZ + 999) / 1000)
`define FL_ERS_SUSP_US 15
`define FL_ERS_SUSP_CYC (`FL_ERS_SUSP_US * `FL_CLK_MHZ)
`define FL_PGM_SUSP_US 20
`define FL_PGM_SUSP_CYC (`FL_PGM_SUSP_US * `FL_CLK_MHZ)
`define FL_POR_MS 10
`define FL_POR_CYC (`FL_POR_MS * 1000 * `FL_CLK_MHZ)
`define FL_SETUP_NS 20
`define FL_SETUP_CYC `FL_NS_TO_CYC(`FL_SETUP_NS)
`define FL_STROBE_NS 60
`define FL_STROBE_CYC `FL_NS_TO_CYC(`FL_STROBE_NS)
`define FL_HOLD_NS 20
`define FL_HOLD_CYC `FL_NS_TO_CYC(`FL_HOLD_NS)
`define FL_ACCESS_NS 120
`define FL_ACCESS_CYC `FL_NS_TO_CYC(`FL_ACCESS_NS)
`define FL_RST_PULSE_NS 500
`define FL_RST_PULSE_CYC `FL_NS_TO_CYC(`FL_RST_PULSE_NS)

`endif

// file: flash_host_pkg.sv
// types of the flash host controller
package flash_host_pkg;

  // software command codes written to the ctrl register
  typedef enum logic [3:0] {
    cmd_read = 4'h0,
    cmd_program = 4'h1,
    cmd_sector_erase = 4'h2,
    cmd_chip_erase = 4'h3,
    cmd_lockdown = 4'h4,
    cmd_suspend = 4'h5,
    cmd_resume = 4'h6,
    cmd_ident_enter = 4'h7,
    cmd_ident_leave = 4'h8,
    cmd_query = 4'h9,
    cmd_user_program = 4'ha,
    cmd_user_lock = 4'hb,
    cmd_user_status = 4'hc,
    cmd_lock_query = 4'hd,
    cmd_hw_reset = 4'he,
    cmd_none = 4'hf
  } cmd_t;

  // sequencer states
  typedef enum logic [7:0] {
    st_idle = 8'h01,
    st_issue = 8'h02,
    st_cycle = 8'h04,
    st_wait_ready = 8'h08,
    st_poll = 8'h10,
    st_leave = 8'h20,
    st_susp_wait = 8'h40,
    st_reset = 8'h80
  } state_t;

endpackage : flash_host_pkg

// file: flash_bus_cycle.sv
// one timed write or read cycle on the flash parallel bus
`timescale 1ns/10ps
`include "flash_host_regs.svh"

module flash_bus_cycle
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic is_read,
  input wire logic [18:0] addr,
  input wire logic [15:0] wdata,
  input wire logic [15:0] dq_in,
  output logic [18:0] flash_addr,
  output logic [15:0] dq_out,
  output logic dq_oe,
  output logic ce_n,
  output logic oe_n,
  output logic we_n,
  output logic [15:0] rdata,
  output logic done
);

  localparam logic [7:0] setup_cyc = 8'(`FL_SETUP_CYC);
  localparam logic [7:0] strobe_cyc = 8'(`FL_STROBE_CYC);
  localparam logic [7:0] hold_cyc = 8'(`FL_HOLD_CYC);
  localparam logic [7:0] access_cyc = 8'(`FL_ACCESS_CYC);

  logic active;
  logic rd;
  logic [1:0] phase;
  logic [7:0] cnt;

  // ***************************************************
  // phase sequencing: setup, strobe, hold for writes; access for reads
  // ***************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      active <= 1'b0;
      rd <= 1'b0;
      phase <= 2'd0;
      cnt <= 8'h00;
      done <= 1'b0;
      ce_n <= 1'b1;
      oe_n <= 1'b1;
      we_n <= 1'b1;
      dq_oe <= 1'b0;
      dq_out <= 16'h0000;
      flash_addr <= 19'h00000;
      rdata <= 16'h0000;
    end
    else
    begin
      done <= 1'b0;
      if (!active)
      begin
        if (start)
        begin
          active <= 1'b1;
          rd <= is_read;
          phase <= 2'd0;
          cnt <= 8'h00;
          flash_addr <= addr;
          dq_out <= wdata;
          ce_n <= 1'b0;
          dq_oe <= !is_read;
          oe_n <= !is_read;
        end
      end
      else if (rd)
      begin
        cnt <= cnt + 8'h01;
        if (cnt == access_cyc - 8'h01)
        begin
          rdata <= dq_in;
          oe_n <= 1'b1;
          ce_n <= 1'b1;
          active <= 1'b0;
          done <= 1'b1;
        end
      end
      else
      begin
        cnt <= cnt + 8'h01;
        case (phase)
          2'd0:
          begin
            if (cnt == setup_cyc - 8'h01)
            begin
              we_n <= 1'b0;
              phase <= 2'd1;
              cnt <= 8'h00;
            end
          end
          2'd1:
          begin
            if (cnt == strobe_cyc - 8'h01)
            begin
              we_n <= 1'b1; // data latched on this rising edge
              phase <= 2'd2;
              cnt <= 8'h00;
            end
          end
          default:
          begin
            if (cnt == hold_cyc - 8'h01)
            begin
              ce_n <= 1'b1;
              dq_oe <= 1'b0;
              active <= 1'b0;
              done <= 1'b1;
            end
          end
        endcase
      end
    end
  end

endmodule : flash_bus_cycle

// file: flash_status_lock_suspend_ctrl.sv
// host controller driving a parallel flash: commands, lockdown, suspend, security store
`timescale 1ns/10ps
`include "flash_host_regs.svh"


module flash_status_lock_suspend_ctrl
#(
  parameter int unsigned por_delay_cyc = `FL_POR_CYC
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [18:0] flash_addr,
  input wire logic [15:0] dq_in,
  output logic [15:0] dq_out,
  output logic dq_oe,
  output logic ce_n,
  output logic oe_n,
  output logic we_n,
  output logic flash_reset_n,
  input wire logic ready_line
);
  import flash_host_pkg::*;

  localparam logic [11:0] ers_susp_cyc = 12'(`FL_ERS_SUSP_CYC);
  localparam logic [11:0] pgm_susp_cyc = 12'(`FL_PGM_SUSP_CYC);
  localparam logic [11:0] rst_pulse_cyc = 12'(`FL_RST_PULSE_CYC);

  state_t state;
  cmd_t cmd;
  logic [18:0] addr_reg;
  logic [15:0] wdata_reg;
  logic [15:0] rdata_reg;
  logic [2:0] step;
  logic [2:0] last_step;
  logic [11:0] wait_cnt;
  logic [31:0] por_cnt;
  logic por_done;
  logic done_flag;
  logic fail_flag;
  logic locked_flag;
  logic user_open_flag;
  logic refused_flag;
  logic op_active;
  logic op_erase;
  logic suspended;
  logic susp_erase;
  logic cyc_start;
  logic cyc_read;
  logic [18:0] cyc_addr;
  logic [15:0] cyc_data;
  logic [15:0] cyc_rdata;
  logic cyc_done;
  logic wr_en;
  logic rd_en;
  logic start_req;
  cmd_t start_cmd;
  logic [35:0] step_word;
  logic accept;
  logic refuse;

  // ***************************************************
  // apb slave: zero wait states, error on unmapped offsets
  // ***************************************************
  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign start_req = wr_en && (paddr == `FL_REG_CTRL) && pwdata[`FL_CTRL_START];
  assign start_cmd = cmd_t'(pwdata[`FL_CTRL_CMD_HI:`FL_CTRL_CMD_LO]);

  // mapped offsets answer okay, others flag an error
  always_comb
  begin
    pslverr = 1'b0;
    if (psel && penable)
    begin
      case (paddr)
        `FL_REG_CTRL, `FL_REG_ADDR, `FL_REG_WDATA, `FL_REG_STATUS, `FL_REG_RDATA:
          pslverr = 1'b0;
        default:
          pslverr = 1'b1;
      endcase
    end
  end

  // read data is registered so prdata changes only on a clock edge
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (psel && !penable && !pwrite)
    begin
      case (paddr)
        `FL_REG_CTRL: prdata <= {24'h000000, cmd, 4'h0};
        `FL_REG_ADDR: prdata <= {13'h0000, addr_reg};
        `FL_REG_WDATA: prdata <= {16'h0000, wdata_reg};
        `FL_REG_STATUS: prdata <= {22'h000000, op_active, suspended, por_done, refused_flag,
                                   ready_line, user_open_flag, locked_flag, fail_flag,
                                   done_flag, (state != st_idle) && (state != st_wait_ready)};
        `FL_REG_RDATA: prdata <= {16'h0000, rdata_reg};
        default: prdata <= 32'h00000000;
      endcase
    end
  end

  // address and write data registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      addr_reg <= `FL_ADDR_RST;
      wdata_reg <= `FL_WDATA_RST;
    end
    else if (wr_en && paddr == `FL_REG_ADDR)
      addr_reg <= pwdata[18:0];
    else if (wr_en && paddr == `FL_REG_WDATA)
      wdata_reg <= pwdata[15:0];
  end

  // ***************************************************
  // power-on hold-off
  // ***************************************************
  // programming before the flash's own power-on delay would be dropped silently
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      por_cnt <= 32'h00000000;
    else if (!por_done)
      por_cnt <= por_cnt + 32'h00000001;
  end
  assign por_done = (por_cnt >= por_delay_cyc);

  // ***************************************************
  // command acceptance
  // ***************************************************
  always_comb
  begin
    accept = 1'b0;
    refuse = 1'b0;
    if (start_req)
    begin
      if (state == st_wait_ready)
      begin
        accept = (start_cmd == cmd_suspend);
        refuse = !accept;
      end
      else if (state != st_idle)
        refuse = 1'b1;
      else
      begin
        case (start_cmd)
          cmd_program, cmd_lockdown, cmd_user_program, cmd_user_lock:
            refuse = !por_done;
          cmd_sector_erase, cmd_chip_erase:
            refuse = !por_done || suspended;
          cmd_suspend:
            refuse = 1'b1;
          cmd_resume:
            refuse = !suspended;
          cmd_none:
            refuse = 1'b1;
          default:
            refuse = 1'b0;
        endcase
        accept = !refuse;
      end
    end
  end

  // ***************************************************
  // bus cycle table per command
  // ***************************************************
  function automatic logic [35:0] step_of(cmd_t c, logic [2:0] i, logic [18:0] a,
                                          logic [15:0] d);
    logic rd;
    logic [18:0] sa;
    logic [15:0] sd;
    rd = 1'b0;
    sa = `FL_A_UNLOCK1;
    sd = `FL_D_UNLOCK1;
    case (c)
      cmd_read: begin rd = 1'b1; sa = a; end
      cmd_suspend: sd = `FL_D_SUSPEND;
      cmd_resume: sd = `FL_D_RESUME;
      cmd_ident_leave: sd = `FL_D_IDENT_LEAVE;
      cmd_query: begin sa = `FL_A_QUERY; sd = `FL_D_QUERY; end
      default:
      begin
        if (i == 3'd1 || i == 3'd4)
        begin
          sa = `FL_A_UNLOCK2;
          sd = `FL_D_UNLOCK2;
        end
        else if (i == 3'd2)
        begin
          case (c)
            cmd_program: sd = `FL_D_PROGRAM;
            cmd_user_program, cmd_user_lock: sd = `FL_D_SEC_STORE;
            cmd_sector_erase, cmd_chip_erase, cmd_lockdown: sd = `FL_D_ERASE_SETUP;
            default: sd = `FL_D_IDENT_ENTER;
          endcase
        end
        else if (i == 3'd3)
        begin
          case (c)
            cmd_program, cmd_user_program: begin sa = a; sd = d; end
            cmd_user_lock: begin sa = `FL_A_USER_BLK; sd = d & ~16'h0002; end
            cmd_user_status: begin rd = 1'b1; sa = `FL_A_USER_BLK; end
            cmd_lock_query: begin rd = 1'b1; sa = a | `FL_A_LOCK_OFS; end
            default: sd = `FL_D_UNLOCK1;
          endcase
        end
        else if (i == 3'd5)
        begin
          case (c)
            cmd_chip_erase: sd = `FL_D_CHIP_ERASE;
            cmd_sector_erase: begin sa = a; sd = `FL_D_SECTOR_ERASE; end
            cmd_lockdown: begin sa = a; sd = `FL_D_LOCKDOWN; end
            default: sd = `FL_D_IDENT_LEAVE;
          endcase
        end
      end
    endcase
    return {rd, sa, sd};
  endfunction : step_of

  // user status and lock query end with ident leave, as must any ident visit
  function automatic logic [2:0] last_of(cmd_t c);
    case (c)
      cmd_ident_enter: return 3'd2;
      cmd_program, cmd_user_program, cmd_user_lock: return 3'd3;
      cmd_user_status, cmd_lock_query: return 3'd4;
      cmd_sector_erase, cmd_chip_erase, cmd_lockdown: return 3'd5;
      default: return 3'd0;
    endcase
  endfunction : last_of

  // the fifth cycle of status queries is the leave word, not an unlock
  always_comb
  begin
    step_word = step_of(cmd, step, addr_reg, wdata_reg);
    if ((cmd == cmd_user_status || cmd == cmd_lock_query) && step == 3'd4)
      step_word = {1'b0, `FL_A_UNLOCK1, `FL_D_IDENT_LEAVE};
  end

  // ***************************************************
  // sequencer
  // ***************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= st_idle;
      cmd <= cmd_none;
      step <= 3'd0;
      last_step <= 3'd0;
      wait_cnt <= 12'h000;
      cyc_start <= 1'b0;
      cyc_read <= 1'b0;
      cyc_addr <= 19'h00000;
      cyc_data <= 16'h0000;
      flash_reset_n <= 1'b1;
    end
    else
    begin
      cyc_start <= 1'b0;
      case (state)
        st_idle, st_wait_ready:
        begin
          if (accept)
          begin
            cmd <= start_cmd;
            step <= 3'd0;
            last_step <= last_of(start_cmd);
            wait_cnt <= 12'h000;
            state <= (start_cmd == cmd_hw_reset) ? st_reset : st_issue;
          end
          else if (state == st_wait_ready && ready_line)
          begin
            cyc_start <= 1'b1;
            cyc_read <= 1'b1;
            cyc_addr <= addr_reg;
            state <= st_poll;
          end
        end
        st_issue:
        begin
          cyc_start <= 1'b1;
          cyc_read <= step_word[35];
          cyc_addr <= step_word[34:16];
          cyc_data <= step_word[15:0];
          state <= st_cycle;
        end
        st_cycle:
        begin
          if (cyc_done)
          begin
            if (step != last_step)
            begin
              step <= step + 3'd1;
              state <= st_issue;
            end
            else if (cmd == cmd_suspend)
              state <= st_susp_wait;
            else if (cmd == cmd_program || cmd == cmd_sector_erase ||
                     cmd == cmd_chip_erase || cmd == cmd_user_program ||
                     cmd == cmd_resume)
              state <= st_wait_ready;
            else
              state <= st_idle;
          end
        end
        st_poll:
        begin
          if (cyc_done)
          begin
            if (cyc_rdata[`FL_D_FAIL_BIT])
            begin
              cyc_start <= 1'b1;
              cyc_read <= 1'b0;
              cyc_addr <= `FL_A_UNLOCK1;
              cyc_data <= `FL_D_IDENT_LEAVE;
              state <= st_leave;
            end
            else
              state <= st_idle;
          end
        end
        st_leave:
        begin
          if (cyc_done)
            state <= st_idle;
        end
        st_susp_wait:
        begin
          wait_cnt <= wait_cnt + 12'h001;
          if (wait_cnt == (op_erase ? ers_susp_cyc : pgm_susp_cyc))
            state <= st_idle;
        end
        st_reset:
        begin
          flash_reset_n <= 1'b0;
          wait_cnt <= wait_cnt + 12'h001;
          if (wait_cnt == rst_pulse_cyc)
          begin
            flash_reset_n <= 1'b1;
            state <= st_idle;
          end
        end
        default:
          state <= st_idle;
      endcase
    end
  end

  // ***************************************************
  // operation context and result flags
  // ***************************************************
  // a flash reset also drops every lockdown; the host clears op_active and suspended but keeps locked_flag
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      op_active <= 1'b0;
      op_erase <= 1'b0;
      suspended <= 1'b0;
      susp_erase <= 1'b0;
    end
    else if (state == st_reset)
    begin
      op_active <= 1'b0;
      suspended <= 1'b0;
    end
    else if (state == st_cycle && cyc_done && step == last_step)
    begin
      case (cmd)
        cmd_program, cmd_user_program:
        begin
          op_active <= 1'b1;
          op_erase <= 1'b0;
        end
        cmd_sector_erase, cmd_chip_erase:
        begin
          op_active <= 1'b1;
          op_erase <= 1'b1;
        end
        cmd_suspend:
        begin
          suspended <= 1'b1;
          susp_erase <= op_erase;
          op_active <= 1'b0;
        end
        cmd_resume:
        begin
          suspended <= 1'b0;
          op_active <= 1'b1;
          op_erase <= susp_erase;
        end
        default:
          op_active <= op_active;
      endcase
    end
    else if (state == st_poll && cyc_done)
    begin
      op_active <= 1'b0;
      op_erase <= suspended ? susp_erase : 1'b0;
    end
  end

  // done and fail: a new start clears them, completion in that cycle wins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      done_flag <= 1'b0;
      fail_flag <= 1'b0;
      refused_flag <= 1'b0;
      locked_flag <= 1'b0;
      user_open_flag <= 1'b0;
      rdata_reg <= 16'h0000;
    end
    else
    begin
      if (refuse)
        refused_flag <= 1'b1;
      else if (accept)
        refused_flag <= 1'b0;
      if (accept)
      begin
        done_flag <= 1'b0;
        fail_flag <= 1'b0;
      end
      if (state == st_poll && cyc_done)
        fail_flag <= cyc_rdata[`FL_D_FAIL_BIT];
      if (state == st_cycle && cyc_done && cyc_read)
      begin
        rdata_reg <= cyc_rdata;
        if (cmd == cmd_lock_query)
          locked_flag <= cyc_rdata[`FL_D_LOCK_FLAG_BIT];
        if (cmd == cmd_user_status)
          user_open_flag <= cyc_rdata[`FL_D_LOCK_DATA_BIT];
      end
      if ((state == st_cycle && cyc_done && step == last_step && cmd != cmd_suspend &&
           cmd != cmd_program && cmd != cmd_sector_erase && cmd != cmd_chip_erase &&
           cmd != cmd_user_program && cmd != cmd_resume) ||
          (state == st_poll && cyc_done && !cyc_rdata[`FL_D_FAIL_BIT]) ||
          (state == st_leave && cyc_done) ||
          (state == st_susp_wait && wait_cnt == (op_erase ? ers_susp_cyc : pgm_susp_cyc)) ||
          (state == st_reset && wait_cnt == rst_pulse_cyc))
        done_flag <= 1'b1;
    end
  end

  // ***************************************************
  // bus cycle engine
  // ***************************************************
  flash_bus_cycle u_cycle
  (
    .pclk(pclk),
    .presetn(presetn),
    .start(cyc_start),
    .is_read(cyc_read),
    .addr(cyc_addr),
    .wdata(cyc_data),
    .dq_in(dq_in),
    .flash_addr(flash_addr),
    .dq_out(dq_out),
    .dq_oe(dq_oe),
    .ce_n(ce_n),
    .oe_n(oe_n),
    .we_n(we_n),
    .rdata(cyc_rdata),
    .done(cyc_done)
  );

endmodule : flash_status_lock_suspend_ctrl

// file: flash_host_monitor.sv
// checker watching the flash host controller ports
`timescale 1ns/10ps
module flash_host_monitor
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic dq_oe,
  input wire logic flash_reset_n
);
  // one clock domain, so clock and reset are named once
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_unmapped_err: assert property (psel && penable && paddr > 8'h10 |->
    pslverr && (pwrite || prdata == 32'h0)) else $error("unmapped access");
  a_mapped_ok: assert property (psel && penable && paddr[1:0] == 2'h0 && paddr <= 8'h10
    |-> !pslverr) else $error("mapped access refused");
  a_strobe_excl: assert property (!we_n |-> oe_n && !ce_n && dq_oe)
    else $error("write strobe without write conditions");
  a_write_pulse: assert property ($fell(we_n) |-> !we_n [*6] ##1 we_n)
    else $error("write strobe width");
  a_ce_setup: assert property ($fell(we_n) |-> !$past(ce_n, 2))
    else $error("select setup");
  a_ce_hold: assert property ($rose(we_n) |-> !ce_n [*2] ##1 ce_n)
    else $error("select hold");
  a_read_drive: assert property (!oe_n |-> !dq_oe && we_n) else $error("read contention");
  a_rst_pulse: assert property ($fell(flash_reset_n) |-> ##49 !flash_reset_n ##1
    flash_reset_n) else $error("flash reset width");
endmodule : flash_host_monitor

// file: flash_dev_model.sv
// behavioural flash device at the far side of the controller
`timescale 1ns/10ps
module flash_dev_model
(
  input wire logic pclk,
  input wire logic flash_reset_n,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic [18:0] flash_addr,
  input wire logic [15:0] dq_out,
  output logic [15:0] dq_in,
  output logic ready_line
);
  logic [15:0] lock = 16'h0000;
  logic fail = 1'b0, ident = 1'b0, pgm = 1'b0, susp = 1'b0, we_d = 1'b1;
  int busy = 0;
  wire logic [3:0] s = flash_addr[18:15];
  // pulled up line, low only while an operation runs unsuspended
  assign ready_line = !(busy > 0 && !susp);
  // commands latch on the rising write strobe
  always @(posedge pclk)
  begin
    we_d <= we_n;
    if (busy > 0 && !susp)
      busy <= busy - 1;
    if (!flash_reset_n)
      {lock, busy, susp, ident, fail, pgm} <= '0;
    else if (we_n && !we_d && !ce_n && oe_n)
    begin
      pgm <= dq_out[7:0] == 8'ha0 && flash_addr == 19'h00555;
      if (pgm)
        if (lock[s]) fail <= 1'b1;
        else busy <= 30;
      else case (dq_out[7:0])
        8'h10: busy <= 400;
        8'h30: if (susp) susp <= 1'b0; else if (lock[s]) fail <= 1'b1; else busy <= 400;
        8'h60: lock[s] <= 1'b1;
        8'h90, 8'h98: ident <= 1'b1;
        8'hb0: susp <= busy > 0;
        8'hf0: {ident, fail} <= 2'b00;
        default: ;
      endcase
    end
  end
  // released bus toggles so a stale value never looks valid
  always @(posedge pclk)
    if (ce_n || oe_n) dq_in <= ~dq_in;
    else if (ident && flash_addr[14:0] == 15'h0002) dq_in <= {15'h0, lock[s]};
    else if (ident && flash_addr[7:0] == 8'h80) dq_in <= 16'h0002;
    else dq_in <= {10'h0, fail && busy == 0, 5'h0};
  initial dq_in = 16'h0000;
endmodule : flash_dev_model

// file: flash_status_lock_suspend_ctrl_tb.sv
// testbench of the flash host controller against a behavioural flash
`timescale 1ns/10ps
module flash_status_lock_suspend_ctrl_tb;
  import flash_host_pkg::*;
  typedef struct packed {cmd_t c; logic [18:0] a; logic [9:0] m; logic [9:0] e;} row_t;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, se;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, dq_oe, ce_n, oe_n, we_n, flash_reset_n, ready_line;
  logic [18:0] flash_addr;
  logic [15:0] dq_in, dq_out;
  int err_total = 0, tests_run = 0, cyc = 0;
  row_t rows [16] = '{'{cmd_program, 19'h08000, 10'h004, 10'h000},
    '{cmd_lockdown, 19'h08000, 10'h004, 10'h000},
    '{cmd_lock_query, 19'h08000, 10'h008, 10'h008},
    '{cmd_program, 19'h08010, 10'h004, 10'h004},
    '{cmd_lock_query, 19'h10000, 10'h008, 10'h000},
    '{cmd_suspend, 19'h0, 10'h040, 10'h040}, '{cmd_resume, 19'h0, 10'h040, 10'h040},
    '{cmd_user_status, 19'h0, 10'h050, 10'h010},
    '{cmd_ident_enter, 19'h0, 10'h040, 10'h000}, '{cmd_query, 19'h0, 10'h040, 10'h000},
    '{cmd_ident_leave, 19'h0, 10'h040, 10'h000}, '{cmd_chip_erase, 19'h0, 10'h044, 10'h000},
    '{cmd_user_program, 19'h0, 10'h044, 10'h000}, '{cmd_user_lock, 19'h0, 10'h040, 10'h000},
    '{cmd_read, 19'h10000, 10'h040, 10'h000}, '{cmd_none, 19'h0, 10'h040, 10'h040}};
  flash_status_lock_suspend_ctrl #(.por_delay_cyc(20)) u_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .flash_addr(flash_addr),
    .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
    .flash_reset_n(flash_reset_n), .ready_line(ready_line));
  flash_dev_model u_flash (.pclk(pclk), .flash_reset_n(flash_reset_n), .ce_n(ce_n),
    .oe_n(oe_n), .we_n(we_n), .flash_addr(flash_addr), .dq_out(dq_out), .dq_in(dq_in),
    .ready_line(ready_line));
  task end_sim;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim
  // one apb transfer, held until pready is seen at a rising edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    se = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      err_total++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task kick(input cmd_t c, input logic [18:0] a);
    apb(1'b1, 8'h04, {13'h0, a});
    apb(1'b1, 8'h08, 32'h5a5a);
    apb(1'b1, 8'h00, {24'h0, c, 4'h1});
  endtask : kick
  // polls until issuing ends and no operation waits, or one is suspended
  task go(input cmd_t c, input logic [18:0] a);
    kick(c, a);
    repeat (3000)
    begin
      apb(1'b0, 8'h0c, 32'h0);
      if (q[0] === 1'b0 && (q[9] === 1'b0 || q[8] === 1'b1)) break;
    end
  endtask : go
  initial forever #5 pclk = ~pclk;
  // hang guard well above the expected run length
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      err_total++;
      end_sim();
    end
  end
  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (25) @(posedge pclk);
    foreach (rows[i])
    begin
      go(rows[i].c, rows[i].a);
      chk("status", {22'h0, rows[i].e}, q & {22'h0, rows[i].m});
      $display("row %0d done", i);
    end
    kick(cmd_sector_erase, 19'h10000);
    repeat (300)
    begin
      apb(1'b0, 8'h0c, 32'h0);
      if (q[9] === 1'b1) break;
    end
    go(cmd_suspend, 19'h0);
    chk("suspended", 32'h100, q & 32'h104);
    go(cmd_sector_erase, 19'h18000);
    chk("erase in suspend", 32'h140, q & 32'h140);
    go(cmd_resume, 19'h0);
    chk("resumed", 32'h0, q & 32'h104);
    go(cmd_hw_reset, 19'h0);
    go(cmd_lock_query, 19'h08000);
    chk("lock after reset", 32'h0, q & 32'h8);
    $display("suspend and reset tests done");
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'h04, 32'h0);
    chk("addr reset", 32'h0, q);
    go(cmd_program, 19'h08000);
    chk("early program", 32'h40, q & 32'hc0);
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped", 32'h1, {31'h0, se});
    $display("second reset test done");
    end_sim();
  end
endmodule : flash_status_lock_suspend_ctrl_tb
bind flash_status_lock_suspend_ctrl flash_host_monitor u_mon (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pslverr(pslverr), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .dq_oe(dq_oe),
  .flash_reset_n(flash_reset_n));
